// File: hdl/aestx_cfg.sv
// status source, status file select and mute slice of the audio transmitter
//
// Summary of operation
// - slave mode, code 00: status bit is bit 26 of the channel's own word.
// - code 01: status bit is bit 26 of the block-sync selected channel.
// - code 10: status from memory-mapped files; code 11 reserved, gives zero.
// - upper selector holds channels 7..4 in 2-bit fields; bits 15:8 read zero.
// - file-select bit n: 0 individual file, 1 common file, for bits 0-31.
// - status bits 32 onward always come from the common file.
// - file select matters only when the channel uses memory-mapped status.
// - block-sync selector 0000..0111 picks channel; sync is bit 29 there.
//
// The strobed register port is this design's own decision.
`default_nettype none
module aestx_cfg
(
  // clock and reset
  input  wire logic                                              core_clk_i,
  input  wire logic                                              reset_i,
  // register port
  input  wire logic [31:0]                                       reg_addr_i,
  input  wire logic [31:0]                                       reg_wdata_i,
  input  wire logic                                              reg_write_i,
  input  wire logic                                              reg_read_i,
  output logic [31:0]                                            reg_rdata_o,
  // audio stream in
  input  wire logic                                              audio_valid_i,
  input  wire logic [aestx_pkg::NUM_CH-1:0][aestx_pkg::WORD_W-1:0] audio_word_i,
  input  wire logic [7:0]                                        cs_index_i,
  // transmitter side
  output logic                                                   tx_valid_o,
  output logic [aestx_pkg::NUM_CH-1:0][aestx_pkg::SAMPLE_W-1:0]  tx_sample_o,
  output logic [aestx_pkg::NUM_CH-1:0]                           tx_cs_o,
  output logic                                                   tx_block_sync_o
);
  typedef struct packed {
    logic [7:0]                                                      src_upper;
    logic [7:0]                                                      file_sel;
    logic [7:0]                                                      mute;
    logic [3:0]                                                      sync_sel;
    logic                                                            slave;
    logic [aestx_pkg::NUM_CH-1:0][aestx_pkg::WORD_W-1:0]             indiv;
    logic [aestx_pkg::COMMON_WORDS-1:0][aestx_pkg::WORD_W-1:0]       common;
    logic [31:0]                                                     rdata;
    logic                                                            valid;
    logic                                                            sync;
  } aestx_cfg_s;

  aestx_cfg_s st;
  aestx_cfg_s next_st;

  logic [aestx_pkg::WORD_W-1:0] sync_word;
  logic                         low_index;
  logic [aestx_pkg::NUM_CH-1:0] indiv_bit;
  logic                         common_bit;
  logic [2:0]                   common_word;
  logic [4:0]                   bit_pos;

  // reserved selector codes pick no channel, so the word reads as zero
  always_comb
  begin
    sync_word   = '0;
    if (st.sync_sel[3] == 1'b0)
    begin
      sync_word = audio_word_i[st.sync_sel[2:0]];
    end
    bit_pos     = cs_index_i[4:0];
    common_word = cs_index_i[7:5];
    low_index   = (cs_index_i < 8'(aestx_pkg::INDIV_LEN));
    common_bit  = 1'b0;
    if (cs_index_i < 8'(aestx_pkg::CS_TOTAL))
    begin
      common_bit = st.common[common_word][bit_pos];
    end
    for (int n = 0; n < aestx_pkg::NUM_CH; n++)
    begin
      indiv_bit[n] = st.indiv[n][bit_pos];
    end
  end

  always_comb
  begin
    next_st       = st;
    next_st.rdata = '0;
    next_st.valid = audio_valid_i;
    if (audio_valid_i)
    begin
      next_st.sync = sync_word[aestx_pkg::SYNC_BIT];
    end
    if (reg_write_i)
    begin
      if (reg_addr_i == aestx_pkg::ADDR_SRC_UPPER)
      begin
        next_st.src_upper = reg_wdata_i[7:0];
      end
      else if (reg_addr_i == aestx_pkg::ADDR_FILE_SEL)
      begin
        next_st.file_sel = reg_wdata_i[7:0];
      end
      else if (reg_addr_i == aestx_pkg::ADDR_MUTE)
      begin
        next_st.mute = reg_wdata_i[7:0];
      end
      else if (reg_addr_i == aestx_pkg::ADDR_SYNC_SEL)
      begin
        next_st.sync_sel = reg_wdata_i[aestx_pkg::SYNC_SEL_W-1:0];
      end
      else if (reg_addr_i == aestx_pkg::ADDR_MODE)
      begin
        next_st.slave = reg_wdata_i[aestx_pkg::MODE_SLAVE_BIT];
      end
      for (int n = 0; n < aestx_pkg::NUM_CH; n++)
      begin
        if (reg_addr_i == aestx_pkg::ADDR_INDIV_BASE + 32'(4 * n))
        begin
          next_st.indiv[n] = reg_wdata_i;
        end
      end
      for (int k = 0; k < aestx_pkg::COMMON_WORDS; k++)
      begin
        if (reg_addr_i == aestx_pkg::ADDR_COMMON_BASE + 32'(4 * k))
        begin
          next_st.common[k] = reg_wdata_i;
        end
      end
    end
    if (reg_read_i)
    begin
      // bits above each select, mute or mode register's 8-bit or narrower field read zero
      if (reg_addr_i == aestx_pkg::ADDR_SRC_UPPER)
      begin
        next_st.rdata = {24'h00_0000, st.src_upper};
      end
      else if (reg_addr_i == aestx_pkg::ADDR_FILE_SEL)
      begin
        next_st.rdata = {24'h00_0000, st.file_sel};
      end
      else if (reg_addr_i == aestx_pkg::ADDR_MUTE)
      begin
        next_st.rdata = {24'h00_0000, st.mute};
      end
      else if (reg_addr_i == aestx_pkg::ADDR_SYNC_SEL)
      begin
        next_st.rdata = {28'h000_0000, st.sync_sel};
      end
      else if (reg_addr_i == aestx_pkg::ADDR_MODE)
      begin
        next_st.rdata = {31'h0000_0000, st.slave};
      end
      for (int n = 0; n < aestx_pkg::NUM_CH; n++)
      begin
        if (reg_addr_i == aestx_pkg::ADDR_INDIV_BASE + 32'(4 * n))
        begin
          next_st.rdata = st.indiv[n];
        end
      end
      for (int k = 0; k < aestx_pkg::COMMON_WORDS; k++)
      begin
        if (reg_addr_i == aestx_pkg::ADDR_COMMON_BASE + 32'(4 * k))
        begin
          next_st.rdata = st.common[k];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      st           <= '0;
      st.src_upper <= aestx_pkg::RST_SRC_UPPER;
      st.file_sel  <= aestx_pkg::RST_FILE_SEL;
      st.mute      <= aestx_pkg::RST_MUTE;
      st.sync_sel  <= aestx_pkg::RST_SYNC_SEL;
      st.slave     <= aestx_pkg::RST_SLAVE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // channels 0..3 have no selector in this slice and use the status files
  genvar g;
  generate
    for (g = 0; g < aestx_pkg::NUM_CH; g++)
    begin : g_chan
      logic [1:0] code;
      if (g < aestx_pkg::LOWER_CH)
      begin : g_low
        assign code = aestx_pkg::SRC_MEMORY;
      end
      else
      begin : g_up
        assign code = st.src_upper[(g - aestx_pkg::LOWER_CH) * aestx_pkg::SRC_FIELD_W +: 2];
      end
      aestx_chan u_chan
      (
        .core_clk_i   (core_clk_i),
        .reset_i      (reset_i),
        .slave_mode_i (st.slave),
        .src_code_i   (code),
        .common_sel_i (st.file_sel[g]),
        .mute_i       (st.mute[g]),
        .valid_i      (audio_valid_i),
        .word_i       (audio_word_i[g]),
        .sync_word_i  (sync_word),
        .low_index_i  (low_index),
        .indiv_bit_i  (indiv_bit[g]),
        .common_bit_i (common_bit),
        .sample_o     (tx_sample_o[g]),
        .cs_o         (tx_cs_o[g])
      );
    end
  endgenerate

  assign reg_rdata_o     = st.rdata;
  assign tx_valid_o      = st.valid;
  assign tx_block_sync_o = st.sync;
endmodule : aestx_cfg
`default_nettype wire

// File: hdl/aestx_pkg.sv
// constants for the transmitter status source, file select and mute slice
`default_nettype none
package aestx_pkg;
  localparam int NUM_CH    = 8;
  localparam int WORD_W    = 32;
  localparam int SAMPLE_W  = 24;
  localparam int REG_W     = 16;
  localparam int CS_BIT    = 26;
  localparam int SYNC_BIT  = 29;
  localparam int CS_TOTAL  = 192;
  localparam int INDIV_LEN = 32;
  localparam int COMMON_WORDS = CS_TOTAL / WORD_W;
  localparam int LOWER_CH  = 4;

  // register byte addresses
  localparam logic [31:0] ADDR_SYNC_SEL   = 32'hce03_0004;
  localparam logic [31:0] ADDR_SRC_UPPER  = 32'hce03_000c;
  localparam logic [31:0] ADDR_FILE_SEL   = 32'hce03_0010;
  localparam logic [31:0] ADDR_MUTE       = 32'hce03_0014;
  localparam logic [31:0] ADDR_MODE       = 32'hce03_0020;
  localparam logic [31:0] ADDR_INDIV_BASE = 32'hce03_0100;
  localparam logic [31:0] ADDR_COMMON_BASE = 32'hce03_0200;

  // field layout
  localparam int SRC_FIELD_W  = 2;
  localparam int SYNC_SEL_W   = 4;
  localparam int MODE_SLAVE_BIT = 0;

  // reset values
  localparam logic [7:0] RST_SRC_UPPER = 8'h00;
  localparam logic [7:0] RST_FILE_SEL  = 8'h00;
  localparam logic [7:0] RST_MUTE      = 8'hff;
  localparam logic [3:0] RST_SYNC_SEL  = 4'h0;
  localparam logic       RST_SLAVE     = 1'b0;

  // status source codes
  localparam logic [1:0] SRC_OWN    = 2'h0;
  localparam logic [1:0] SRC_SYNC   = 2'h1;
  localparam logic [1:0] SRC_MEMORY = 2'h2;
  localparam logic [1:0] SRC_RSVD   = 2'h3;
endpackage : aestx_pkg
`default_nettype wire

// File: hdl/aestx_chan.sv
// one transmitter channel: status bit source choice and mute
`default_nettype none
module aestx_chan
(
  // clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_i,
  // configuration
  input  wire logic                          slave_mode_i,
  input  wire logic [1:0]                    src_code_i,
  input  wire logic                          common_sel_i,
  input  wire logic                          mute_i,
  // audio words and status file bits
  input  wire logic                          valid_i,
  input  wire logic [aestx_pkg::WORD_W-1:0]  word_i,
  input  wire logic [aestx_pkg::WORD_W-1:0]  sync_word_i,
  input  wire logic                          low_index_i,
  input  wire logic                          indiv_bit_i,
  input  wire logic                          common_bit_i,
  // transmitter side
  output logic [aestx_pkg::SAMPLE_W-1:0]     sample_o,
  output logic                               cs_o
);
  typedef struct packed {
    logic [aestx_pkg::SAMPLE_W-1:0] sample;
    logic                           cs;
  } aestx_chan_s;

  aestx_chan_s st;
  aestx_chan_s next_st;
  logic        mem_bit;

  always_comb
  begin
    next_st = st;
    // first 32 bits from own or common file, the rest always common
    mem_bit = (low_index_i && !common_sel_i) ? indiv_bit_i : common_bit_i;
    if (valid_i)
    begin
      next_st.sample = mute_i ? '0 : word_i[aestx_pkg::SAMPLE_W-1:0];
      if (!slave_mode_i)
      begin
        next_st.cs = mem_bit;
      end
      else
      begin
        unique case (src_code_i)
          aestx_pkg::SRC_OWN:    next_st.cs = word_i[aestx_pkg::CS_BIT];
          aestx_pkg::SRC_SYNC:   next_st.cs = sync_word_i[aestx_pkg::CS_BIT];
          aestx_pkg::SRC_MEMORY: next_st.cs = mem_bit;
          aestx_pkg::SRC_RSVD:   next_st.cs = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sample_o = st.sample;
  assign cs_o     = st.cs;
endmodule : aestx_chan
`default_nettype wire

// File: verif/aestx_cfg_sva.sv
// assertions on the status source, file select and mute slice
`default_nettype none
module aestx_cfg_sva
(
  // clock and reset
  input wire logic             core_clk_i,
  input wire logic             reset_i,
  // register port
  input wire logic [31:0]      reg_addr_i,
  input wire logic [31:0]      reg_wdata_i,
  input wire logic             reg_write_i,
  input wire logic             reg_read_i,
  input wire logic [31:0]      reg_rdata_o,
  // stream
  input wire logic             audio_valid_i,
  input wire logic [7:0][31:0] audio_word_i,
  input wire logic [7:0]       tx_cs_o,
  input wire logic [7:0][23:0] tx_sample_o,
  input wire logic             tx_block_sync_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic       slave;
  logic [7:0] src;
  logic [3:0] sel;
  logic [7:0] mute;
  // shadow of the mode, source, sync select and mute registers the stream depends on
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      slave <= 1'b0;
      src   <= 8'h00;
      sel   <= 4'h0;
      mute  <= 8'hff;
    end
    else if (reg_write_i)
    begin
      case (reg_addr_i)
        aestx_pkg::ADDR_MODE:      slave <= reg_wdata_i[0];
        aestx_pkg::ADDR_SRC_UPPER: src   <= reg_wdata_i[7:0];
        aestx_pkg::ADDR_SYNC_SEL:  sel   <= reg_wdata_i[3:0];
        aestx_pkg::ADDR_MUTE:      mute  <= reg_wdata_i[7:0];
        default:                   slave <= slave;
      endcase
    end
  end
  a_read_quiet: assert property (!reg_read_i |=> reg_rdata_o == 32'h0)
    else $error("read data not idle");
  a_upper_read: assert property (reg_read_i && reg_addr_i == aestx_pkg::ADDR_SRC_UPPER
    |=> reg_rdata_o == {24'h0, src})
    else $error("source select read wrong");
  a_file_upper: assert property (reg_read_i && reg_addr_i == aestx_pkg::ADDR_FILE_SEL
    |=> reg_rdata_o[31:8] == 24'h0)
    else $error("file select upper bits set");
  a_mute_read: assert property (reg_read_i && reg_addr_i == aestx_pkg::ADDR_MUTE
    |=> reg_rdata_o == {24'h0, mute})
    else $error("mute read wrong");
  a_mute_zero: assert property (audio_valid_i && mute[1] |=> tx_sample_o[1] == 24'h0)
    else $error("muted sample not zero");
  a_mute_pass: assert property (audio_valid_i && !mute[7]
    |=> tx_sample_o[7] == $past(audio_word_i[7][23:0]))
    else $error("unmuted sample altered");
  a_own_bit: assert property (audio_valid_i && slave && src[1:0] == 2'h0
    |=> tx_cs_o[4] == $past(audio_word_i[4][26]))
    else $error("own status bit wrong");
  a_sync_bit: assert property (audio_valid_i && slave && src[3:2] == 2'h1 && !sel[3]
    |=> tx_cs_o[5] == $past(audio_word_i[sel[2:0]][26]))
    else $error("selected channel status bit wrong");
  a_resv_zero: assert property (audio_valid_i && slave && src[7:6] == 2'h3
    |=> !tx_cs_o[7])
    else $error("reserved code status not zero");
  a_block_sync: assert property (audio_valid_i && !sel[3]
    |=> tx_block_sync_o == $past(audio_word_i[sel[2:0]][29]))
    else $error("block sync wrong");
endmodule : aestx_cfg_sva
bind aestx_cfg aestx_cfg_sva u_sva
(
  .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .audio_valid_i(audio_valid_i), .audio_word_i(audio_word_i),
  .tx_cs_o(tx_cs_o), .tx_sample_o(tx_sample_o), .tx_block_sync_o(tx_block_sync_o)
);
`default_nettype wire

// File: verif/aestx_src.sv
// audio stream source feeding the transmitter slice
`default_nettype none
module aestx_src
(
  // clock
  input  wire logic        core_clk_i,
  // stream out
  output logic             audio_valid_o,
  output logic [7:0][31:0] audio_word_o,
  output logic [7:0]       cs_index_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    audio_valid_o = 1'b0;
    audio_word_o  = '0;
    cs_index_o    = 8'h00;
  end
  // one sample set; words scrambled once taken
  task send(input logic [7:0][31:0] w, input logic [7:0] idx);
    @(posedge core_clk_i);
    audio_valid_o <= 1'b1;
    audio_word_o  <= w;
    cs_index_o    <= idx;
    @(posedge core_clk_i);
    audio_valid_o <= 1'b0;
    audio_word_o  <= ~w;
    cs_index_o    <= ~idx;
  endtask : send
endmodule : aestx_src
`default_nettype wire

// File: verif/aestx_cfg_bench.sv
// self-checking bench for the status source, file select and mute slice
`default_nettype none
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module aestx_cfg_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic             core_clk_i = 1'b0;
  logic             reset_i = 1'b1;
  logic [31:0]      reg_addr_i = 32'h0;
  logic [31:0]      reg_wdata_i = 32'h0;
  logic             reg_write_i = 1'b0;
  logic             reg_read_i = 1'b0;
  logic [31:0]      reg_rdata_o;
  logic             audio_valid_i;
  logic [7:0][31:0] audio_word_i;
  logic [7:0]       cs_index_i;
  logic             tx_valid_o;
  logic [7:0][23:0] tx_sample_o;
  logic [7:0]       tx_cs_o;
  logic             tx_block_sync_o;
  logic [7:0][31:0] w;
  int               sync_ch = 0;
  int               failures = 0;
  int               samples_checked = 0;
  always #50 core_clk_i = ~core_clk_i;
  aestx_src u_src (.core_clk_i(core_clk_i), .audio_valid_o(audio_valid_i),
    .audio_word_o(audio_word_i), .cs_index_o(cs_index_i));
  aestx_cfg u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .audio_valid_i(audio_valid_i), .audio_word_i(audio_word_i),
    .cs_index_i(cs_index_i), .tx_valid_o(tx_valid_o), .tx_sample_o(tx_sample_o),
    .tx_cs_o(tx_cs_o), .tx_block_sync_o(tx_block_sync_o));
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK("rdata", e, reg_rdata_o);
  endtask : rd
  // one sample set; status of channels 7..4 checked when cc is set
  task xfer(input int k, input logic [7:0] idx, input logic [7:0] m, input logic cc,
            input logic mb);
    for (int n = 0; n < 8; n++)
      w[n] = {2'h0, 1'((n + k) % 2), 2'h0, 1'((n + k) % 2), 2'h0, 24'(n * 24'h10101 + k)};
    u_src.send(w, idx);
    @(negedge core_clk_i);
    `CHK("valid", 1'b1, tx_valid_o);
    `CHK("block_sync", sync_ch < 8 ? w[sync_ch][29] : 1'b0, tx_block_sync_o);
    for (int n = 0; n < 8; n++)
      `CHK("sample", m[n] ? 24'h0 : w[n][23:0], tx_sample_o[n]);
    if (cc)
      `CHK("status", {1'b0, mb, w[3][26], w[4][26]}, tx_cs_o[7:4]);
  endtask : xfer
  task close_out;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    #200000;
    failures++;
    close_out;
  end
  initial
  begin
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(aestx_pkg::ADDR_SRC_UPPER, 32'h0);
    rd(aestx_pkg::ADDR_FILE_SEL, 32'h0);
    rd(aestx_pkg::ADDR_MUTE, 32'h000000ff);
    rd(32'hce03_0030, 32'h0);
    xfer(0, 8'h00, 8'hff, 1'b0, 1'b0);
    $display("test reset done");
    wr(aestx_pkg::ADDR_SRC_UPPER, 32'hffffffff);
    rd(aestx_pkg::ADDR_SRC_UPPER, 32'h000000ff);
    wr(aestx_pkg::ADDR_FILE_SEL, 32'hffffffff);
    rd(aestx_pkg::ADDR_FILE_SEL, 32'h000000ff);
    wr(aestx_pkg::ADDR_MUTE, 32'h0000ff0f);
    rd(aestx_pkg::ADDR_MUTE, 32'h0000000f);
    wr(32'hce03_0030, 32'hffffffff);
    rd(32'hce03_0030, 32'h0);
    xfer(1, 8'h00, 8'h0f, 1'b0, 1'b0);
    $display("test registers done");
    wr(aestx_pkg::ADDR_MODE, 32'h1);
    rd(aestx_pkg::ADDR_MODE, 32'h1);
    wr(aestx_pkg::ADDR_SYNC_SEL, 32'h3);
    sync_ch = 3;
    wr(aestx_pkg::ADDR_SRC_UPPER, 32'he4);
    wr(aestx_pkg::ADDR_FILE_SEL, 32'h50);
    wr(aestx_pkg::ADDR_INDIV_BASE, 32'h20);
    wr(aestx_pkg::ADDR_COMMON_BASE, 32'hffffffff);
    wr(aestx_pkg::ADDR_COMMON_BASE + 32'h4, 32'h100);
    xfer(0, 8'd5, 8'h0f, 1'b1, 1'b1);
    `CHK("status_low", 4'h1, tx_cs_o[3:0]);
    xfer(1, 8'd5, 8'h0f, 1'b1, 1'b1);
    wr(aestx_pkg::ADDR_FILE_SEL, 32'h0);
    xfer(0, 8'd5, 8'h0f, 1'b1, 1'b0);
    xfer(1, 8'd40, 8'h0f, 1'b1, 1'b1);
    `CHK("status_low", 4'hf, tx_cs_o[3:0]);
    wr(aestx_pkg::ADDR_SYNC_SEL, 32'h8);
    sync_ch = 8;
    xfer(1, 8'd5, 8'h0f, 1'b0, 1'b0);
    `CHK("status_sync", 1'b0, tx_cs_o[5]);
    $display("test status sources done");
    wr(aestx_pkg::ADDR_MODE, 32'h0);
    rd(aestx_pkg::ADDR_MODE, 32'h0);
    xfer(1, 8'd5, 8'h0f, 1'b0, 1'b0);
    `CHK("status_master", 8'h01, tx_cs_o);
    $display("test master mode done");
    close_out;
  end
endmodule : aestx_cfg_bench
`default_nettype wire
